/* test/bsr_prog_model.sv */
// Purpose: Model of the circuit program that drives the shift register pins.
// Assumes: Pins change right after a rising clk edge.
// Notes:   Each level is held at least 4 cycles, above the 3-cycle minimum of the synchroniser.
`timescale 1ns/1ns
`default_nettype none

module bsr_prog_model (
	input  wire logic clk,
	output logic      trg,
	output logic      dir,
	output logic      din,
	output logic      clr,
	output logic      pwr
);
	initial begin
		{trg, dir, din, clr, pwr} = 5'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// One program instance drives every pin, inside the four-instance limit
	task automatic pulse(input logic t, input logic c, input logic p, input logic d,
		input logic r);
		din <= d;
		dir <= r;
		repeat (4) @(posedge clk);
		trg <= t;
		clr <= c;
		pwr <= p;
		repeat (4) @(posedge clk);
		// Falls are sent too, so a shift on the fall would show
		{trg, clr, pwr} <= 3'h0;
		repeat (6) @(posedge clk);
	endtask
endmodule

`default_nettype wire

/* test/tb_top.sv */
// Purpose: Self-checking bench of the shift register block.
// Assumes: Bus and pins driven right after rising clk edges.
// Notes:   Expected bytes are worked out by hand from the shift order.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import bsr_pkg::*;
	logic              clk;
	logic              rst;
	logic              wr;
	logic              rd;
	logic              q;
	logic              gotq;
	logic              trg;
	logic              dir;
	logic              din;
	logic              clr;
	logic              pwr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] got;
	int                bad_count;
	int                tests_run;
	int                cycles;

	bsr_shift bsr_shift_i (.clk(clk), .rst(rst), .trg_pin(trg), .dir_pin(dir), .din_pin(din),
		.clr_pin(clr), .pwr_up_pin(pwr), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .q(q));
	bsr_prog_model bsr_prog_model_i (.clk(clk), .trg(trg), .dir(dir), .din(din), .clr(clr),
		.pwr(pwr));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Whole run needs about 310 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] act);
		tests_run++;
		if (act !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, act);
		end
	endtask

	task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
		gotq = q;
		check("rdata", exp, got);
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk(ADDR_CTRL, 32'h0000_0000);
		rd_chk(ADDR_CELLS, 32'h0000_0000);
		check("q", 32'h0000_0000, {31'h0000_0000, gotq});
	endtask

	task automatic t_up();
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0005);
	endtask

	task automatic t_down();
		bus_wr(ADDR_CTRL, 32'h0000_0001);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		rd_chk(ADDR_CELLS, 32'h0000_6005);
	endtask

	// Walk the output over every cell of byte 2, whose value is 8'h60
	task automatic t_select();
		logic [7:0] b;
		b = 8'h60;
		for (int p = 0; p < 8; p++) begin
			bus_wr(ADDR_CTRL, 32'h0000_0001 | (DATA_W'(p) << CTRL_POS_LSB));
			rd_chk(ADDR_STAT, {16'h0000, b, 7'h00, b[p]});
			check("q", {31'h0000_0000, b[p]}, {31'h0000_0000, gotq});
		end
	endtask

	task automatic t_clear();
		bus_wr(ADDR_CTRL, 32'h0000_0001);
		bsr_prog_model_i.pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0005);
		bsr_prog_model_i.pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0005);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0105);
	endtask

	task automatic t_power();
		bus_wr(ADDR_CTRL, 32'h0000_0021);
		bsr_prog_model_i.pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0105);
		bus_wr(ADDR_CTRL, 32'h0000_0000);
		bsr_prog_model_i.pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0000);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		rd_chk(ADDR_CELLS, 32'h0000_0001);
	endtask

	// Unmapped and read-only places leave the state alone
	task automatic t_bus();
		bus_wr(4'hC, 32'hFFFF_FFFF);
		bus_wr(ADDR_CELLS, 32'hFFFF_FFFF);
		rd_chk(4'hC, 32'h0000_0000);
		rd_chk(ADDR_CELLS, 32'h0000_0001);
		rd_chk(ADDR_CTRL, 32'h0000_0000);
	endtask

	// Bytes 3 and 4, every control field read back, then a reset in mid-run
	task automatic t_bytes();
		bus_wr(ADDR_CTRL, 32'h0000_003F);
		rd_chk(ADDR_CTRL, 32'h0000_003F);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		rd_chk(ADDR_STAT, 32'h0000_8001);
		rd_chk(ADDR_CELLS, 32'h8000_0001);
		bus_wr(ADDR_CTRL, 32'h0000_0002);
		bsr_prog_model_i.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		rd_chk(ADDR_CELLS, 32'h8001_0001);
		bsr_prog_model_i.pulse(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		rd_chk(ADDR_CELLS, 32'h8000_0001);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(ADDR_CELLS, 32'h0000_0000);
		rd_chk(ADDR_CTRL, 32'h0000_0000);
		check("q", 32'h0000_0000, {31'h0000_0000, gotq});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0000_0000;
		bad_count = 0;
		tests_run = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_up();
		t_down();
		t_select();
		t_clear();
		t_power();
		t_bus();
		t_bytes();
		report_and_stop();
	end
endmodule

`default_nettype wire

/* verilog/bsr_shift.sv */
// Purpose: 8-bit bidirectional shift register function, four bytes, one selected.
// Assumes: Pins are asynchronous and pass two flops; 25 MHz clk; sync reset.
// Notes:   Edges are judged on synchronised levels, so pins need >2 cycles per level.
`timescale 1ns/1ns
`default_nettype none

// Kept beside bsr_shift, which imports it; tb_top imports it too, so this file must be compiled first
package bsr_pkg;
	localparam int BSR_BITS  = 8;
	localparam int BSR_BYTES = 4;
	localparam int BSR_TOTAL = BSR_BITS * BSR_BYTES;
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 32;

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CELLS = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_STAT  = 4'h8;

	// Control and status field layout
	localparam int CTRL_IDX_LSB = 0;
	localparam int CTRL_POS_LSB = 2;
	localparam int CTRL_RET_BIT = 5;
	localparam int STAT_Q_BIT   = 0;
	localparam int STAT_SEL_LSB = 8;

	// Pin slots in the synchroniser vectors
	localparam int PIN_TRG = 0;
	localparam int PIN_DIR = 1;
	localparam int PIN_DIN = 2;
	localparam int PIN_CLR = 3;
	localparam int PIN_PWR = 4;
	localparam int PIN_N   = 5;

	localparam logic [BSR_TOTAL-1:0] BYTE_MASK  = 32'h0000_00FF;
	localparam logic [BSR_BITS-1:0]  BYTE_EMPTY = 8'h00;

	typedef struct packed {
		logic [PIN_N-1:0]  s1;
		logic [PIN_N-1:0]  s2;
		logic [PIN_N-1:0]  prev;
		logic [1:0]        idx;
		logic [2:0]        pos;
		logic              ret;
		logic [DATA_W-1:0] rdata;
		logic              q;
	} bsr_state_s;
endpackage

////////////////////////////////////////////////////////////////////////////////
module bsr_shift
	import bsr_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      trg_pin,
	input  wire logic                      dir_pin,
	input  wire logic                      din_pin,
	input  wire logic                      clr_pin,
	input  wire logic                      pwr_up_pin,
	input  wire logic [bsr_pkg::ADDR_W-1:0] addr,
	input  wire logic [bsr_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic      [bsr_pkg::DATA_W-1:0] rdata,
	output logic                           q
);
	import bsr_pkg::*;

	localparam bsr_state_s STATE_RST = '0;

	bsr_state_s              st_reg;
	bsr_state_s              st_next;
	logic [BSR_TOTAL-1:0]    cells;
	logic [PIN_N-1:0]        rise;
	logic                    trg_rise;
	logic                    clr_rise;
	logic                    pwr_rise;
	logic                    shift_en;
	logic                    wipe_all;
	logic [BSR_BITS-1:0]     sel_byte;
	logic [BSR_BITS-1:0]     shifted;
	logic [4:0]              byte_ofs;

	////////////////////////////////////////////////////////////////////////////
	// Edge detection on the second synchroniser stage only
	assign rise     = st_reg.s2 & ~st_reg.prev;
	assign trg_rise = rise[PIN_TRG];
	assign clr_rise = rise[PIN_CLR];
	assign pwr_rise = rise[PIN_PWR];
	assign byte_ofs = {st_reg.idx, 3'b000};
	assign sel_byte = cells[byte_ofs +: BSR_BITS];

	// Clear on the same byte in the same cycle suppresses the shift
	assign shift_en = trg_rise && !clr_rise;
	assign wipe_all = pwr_rise && !st_reg.ret;

	always_comb begin
		if (st_reg.s2[PIN_DIR]) begin
			shifted = {st_reg.s2[PIN_DIN], sel_byte[BSR_BITS-1:1]};
		end else begin
			shifted = {sel_byte[BSR_BITS-2:0], st_reg.s2[PIN_DIN]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Four bytes kept apart; only the selected one is shifted or cleared, but a power wipe empties all four
	bsr_store #(
		.BYTES (BSR_BYTES),
		.BITS  (BSR_BITS)
	) u_store (
		.clk      (clk),
		.rst      (rst),
		.wr_en    (shift_en),
		.wr_idx   (st_reg.idx),
		.wr_data  (shifted),
		.clr_en   (clr_rise),
		.clr_idx  (st_reg.idx),
		.wipe_all (wipe_all),
		.cells    (cells)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next      = st_reg;
		st_next.s1   = {pwr_up_pin, clr_pin, din_pin, dir_pin, trg_pin};
		st_next.s2   = st_reg.s1;
		st_next.prev = st_reg.s2;
		if (wr && addr == ADDR_CTRL) begin
			st_next.idx = wdata[CTRL_IDX_LSB +: 2];
			st_next.pos = wdata[CTRL_POS_LSB +: 3];
			st_next.ret = wdata[CTRL_RET_BIT];
		end
		st_next.rdata = '0;
		if (rd) begin
			unique case (addr)
				ADDR_CTRL: begin
					st_next.rdata[CTRL_IDX_LSB +: 2] = st_reg.idx;
					st_next.rdata[CTRL_POS_LSB +: 3] = st_reg.pos;
					st_next.rdata[CTRL_RET_BIT]      = st_reg.ret;
				end
				ADDR_CELLS: begin
					st_next.rdata = cells;
				end
				ADDR_STAT: begin
					st_next.rdata[STAT_Q_BIT]              = st_reg.q;
					st_next.rdata[STAT_SEL_LSB +: BSR_BITS] = sel_byte;
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end
		// Registered so the output never glitches while the byte rewrites
		st_next.q = cells[{st_reg.idx, st_reg.pos}];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	assign q     = st_reg.q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_shift_up;
		@(posedge clk) disable iff (rst)
		(shift_en && !wipe_all && !st_reg.s2[PIN_DIR] && !(wr && addr == ADDR_CTRL))
		|=> sel_byte == {$past(sel_byte[BSR_BITS-2:0]), $past(st_reg.s2[PIN_DIN])};
	endproperty
	a_shift_up: assert property (p_shift_up) else $error("upward shift wrong");

	property p_shift_down;
		@(posedge clk) disable iff (rst)
		(shift_en && !wipe_all && st_reg.s2[PIN_DIR] && !(wr && addr == ADDR_CTRL))
		|=> sel_byte == {$past(st_reg.s2[PIN_DIN]), $past(sel_byte[BSR_BITS-1:1])};
	endproperty
	a_shift_down: assert property (p_shift_down) else $error("downward shift wrong");

	property p_trig_pin_shift;
		@(posedge clk) disable iff (rst)
		($rose(st_reg.s1[PIN_TRG]) && !st_reg.s1[PIN_CLR] && !st_reg.s1[PIN_PWR])
		##1 !clr_rise |-> shift_en;
	endproperty
	a_trig_pin_shift: assert property (p_trig_pin_shift) else $error("rise not shifted");

	property p_idle_stable;
		@(posedge clk) disable iff (rst)
		(!trg_rise && !clr_rise && !pwr_rise) |=> $stable(cells);
	endproperty
	a_idle_stable: assert property (p_idle_stable) else $error("bits moved without edge");

	property p_other_bytes;
		@(posedge clk) disable iff (rst)
		(!wipe_all) |=> ((cells ^ $past(cells)) & ~$past(BYTE_MASK << byte_ofs)) == '0;
	endproperty
	a_other_bytes: assert property (p_other_bytes) else $error("unselected byte changed");

	property p_clear;
		@(posedge clk) disable iff (rst)
		clr_rise && !(wr && addr == ADDR_CTRL) |=> sel_byte == BYTE_EMPTY;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left bits set");

	property p_clear_wins;
		@(posedge clk) disable iff (rst)
		(clr_rise && trg_rise && !(wr && addr == ADDR_CTRL)) |=> sel_byte == BYTE_EMPTY;
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("shift beat clear");

	property p_q_follows;
		@(posedge clk) disable iff (rst)
		1'b1 |=> q == $past(cells[{st_reg.idx, st_reg.pos}]);
	endproperty
	a_q_follows: assert property (p_q_follows) else $error("output not selected bit");

	property p_wipe;
		@(posedge clk) disable iff (rst)
		wipe_all |=> cells == '0;
	endproperty
	a_wipe: assert property (p_wipe) else $error("power loss kept bits");

	property p_keep;
		@(posedge clk) disable iff (rst)
		(pwr_rise && st_reg.ret && !trg_rise && !clr_rise) |=> $stable(cells);
	endproperty
	a_keep: assert property (p_keep) else $error("retentive bits lost");

	property p_fall_quiet;
		@(posedge clk) disable iff (rst)
		(!st_reg.s2[PIN_TRG] && st_reg.prev[PIN_TRG] && !clr_rise && !pwr_rise)
		|=> $stable(cells);
	endproperty
	a_fall_quiet: assert property (p_fall_quiet) else $error("trigger fall moved bits");

	// The edge detector must never report one rise on two cycles
	property p_one_shift;
		@(posedge clk) disable iff (rst)
		shift_en |=> !shift_en;
	endproperty
	a_one_shift: assert property (p_one_shift) else $error("one rise shifted twice");

	property p_idx_hold;
		@(posedge clk) disable iff (rst)
		!(wr && addr == ADDR_CTRL) |=> $stable(byte_ofs);
	endproperty
	a_idx_hold: assert property (p_idx_hold) else $error("byte index moved");

	property p_sel_stat;
		@(posedge clk) disable iff (rst)
		(rd && addr == ADDR_STAT) |=> rdata[STAT_SEL_LSB +: BSR_BITS] == $past(sel_byte);
	endproperty
	a_sel_stat: assert property (p_sel_stat) else $error("selected byte view wrong");

	property p_clear_q;
		@(posedge clk) disable iff (rst)
		(clr_rise && !(wr && addr == ADDR_CTRL)) |=> ##1 (q == 1'b0);
	endproperty
	a_clear_q: assert property (p_clear_q) else $error("output set after clear");

	property p_q_stat;
		@(posedge clk) disable iff (rst)
		(rd && addr == ADDR_STAT) |=> rdata[STAT_Q_BIT] == $past(q);
	endproperty
	a_q_stat: assert property (p_q_stat) else $error("status output bit wrong");

	property p_ctrl_read;
		@(posedge clk) disable iff (rst)
		(rd && addr == ADDR_CTRL) |=> rdata[CTRL_POS_LSB +: 3] == $past(st_reg.pos);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("bit position readback wrong");

	property p_cells_read;
		@(posedge clk) disable iff (rst)
		(rd && addr == ADDR_CELLS) |=> rdata == $past(cells);
	endproperty
	a_cells_read: assert property (p_cells_read) else $error("cell readback wrong");

	// Any selection reads zero once the bytes are emptied
	property p_wipe_q;
		@(posedge clk) disable iff (rst)
		wipe_all |=> ##1 (q == 1'b0);
	endproperty
	a_wipe_q: assert property (p_wipe_q) else $error("output set after power loss");

	property p_ret_hold;
		@(posedge clk) disable iff (rst)
		!(wr && addr == ADDR_CTRL) |=> $stable(st_reg.ret);
	endproperty
	a_ret_hold: assert property (p_ret_hold) else $error("retentive setting moved");

	c_shift_up:   cover property (@(posedge clk) disable iff (rst) shift_en && !st_reg.s2[PIN_DIR]);
	c_shift_down: cover property (@(posedge clk) disable iff (rst) shift_en && st_reg.s2[PIN_DIR]);
	c_clear_both: cover property (@(posedge clk) disable iff (rst) clr_rise && trg_rise);
	c_wipe:       cover property (@(posedge clk) disable iff (rst) wipe_all ##1 cells == '0);
	c_keep:       cover property (@(posedge clk) disable iff (rst) pwr_rise && st_reg.ret);
endmodule

`default_nettype wire

/* verilog/bsr_store.sv */
// Purpose: Byte store of the shift register block: four registered bytes.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Store outputs are registered; writers see the new bytes one cycle later.
`timescale 1ns/1ns
`default_nettype none

module bsr_store #(
	parameter int BYTES = 4,
	parameter int BITS  = 8
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     wr_en,
	input  wire logic [1:0]               wr_idx,
	input  wire logic [BITS-1:0]          wr_data,
	input  wire logic                     clr_en,
	input  wire logic [1:0]               clr_idx,
	input  wire logic                     wipe_all,
	output logic      [BYTES*BITS-1:0]    cells
);
	logic [BYTES*BITS-1:0] cells_reg;
	logic [BYTES*BITS-1:0] cells_next;

	////////////////////////////////////////////////////////////////////////////
	// Per-byte next value; clear beats shift, wipe beats both
	genvar g;
	generate
		for (g = 0; g < BYTES; g++) begin : g_byte
			always_comb begin
				cells_next[g*BITS +: BITS] = cells_reg[g*BITS +: BITS];
				if (wipe_all || (clr_en && clr_idx == 2'(g))) begin
					cells_next[g*BITS +: BITS] = '0;
				end else if (wr_en && wr_idx == 2'(g)) begin
					cells_next[g*BITS +: BITS] = wr_data;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			cells_reg <= '0;
		end else begin
			cells_reg <= cells_next;
		end
	end

	assign cells = cells_reg;
endmodule

`default_nettype wire
